// *** shared/lec_pkg.sv ***
// Purpose: Constants and carrier types for the lookup engine control block
// Assumes: 32-bit APB, each register on one aligned word
// Notes:   Flush trigger register is a companion control word owned here
package lec_pkg;
	localparam logic [11:0] IDX_CTRL_ONE = 12'h310;    // Flush triggers, word index
	localparam logic [11:0] IDX_CTRL_TWO = 12'h312;    // lookup_engine_control_two, word index
	localparam logic [11:0] IDX_STATUS   = 12'h314;    // Flush busy status, word index
	// One aligned word per register, so the byte address is four times the low ten bits of the index
	localparam logic [11:0] OFF_CTRL_ONE = {IDX_CTRL_ONE[9:0], 2'b00}; // Flush triggers
	localparam logic [11:0] OFF_CTRL_TWO = {IDX_CTRL_TWO[9:0], 2'b00}; // Control two
	localparam logic [11:0] OFF_STATUS   = {IDX_STATUS[9:0], 2'b00};   // Flush status
	localparam int          BIT_TRAP     = 6;          // Double tag multicast trap
	localparam int          BIT_DYN_FLT  = 5;          // Dynamic entry egress filter
	localparam int          BIT_STA_FLT  = 4;          // Static entry egress filter
	localparam int          POS_FLUSH    = 2;          // Flush selection low bit
	localparam int          BIT_FL_ALL   = 5;          // Full-table flush trigger
	localparam int          BIT_FL_STP   = 4;          // Spanning-tree flush trigger
	localparam logic [7:0]  CTRL_TWO_RST = 8'h00;      // All fields zero after reset
	localparam logic [1:0]  FL_NONE      = 2'h0;       // No class selected / done
	localparam logic [1:0]  FL_DYN       = 2'h1;       // Dynamic only
	localparam logic [1:0]  FL_STA       = 2'h2;       // Static only
	localparam logic [1:0]  FL_BOTH      = 2'h3;       // Both classes
	typedef enum logic [1:0] {
		PRI_DA   = 2'b00,
		PRI_SA   = 2'b01,
		PRI_HIGH = 2'b10,
		PRI_LOW  = 2'b11
	} lec_pri_sel_t;
	// Lookup result from the forwarding engine
	typedef struct packed {
		logic       hit;       // Address lookup hit
		logic       is_static; // Hit entry is static
		logic       rsvd_mc;   // Frame is reserved multicast
		logic [6:0] alu_map;   // Address-table port map
		logic [6:0] vlan_map;  // VLAN-table port map
		logic [2:0] da_pri;    // Priority from destination lookup
		logic [2:0] sa_pri;    // Priority from source lookup
	} lec_lookup_t;
endpackage

// *** rtl/lec_ctrl.sv ***
// Purpose: Lookup engine control register two, flush sequencing, port and
//          priority selection for the address lookup engine
// Assumes: Single pclk domain; lookup inputs synchronous to pclk
// Notes:   Flush runs for a parameterised cycle count then reports done
// Notes on behaviour
// - Double tag trap sends reserved multicast to host
// - Dynamic hit ANDs address and VLAN maps
// - Static hit ANDs address and VLAN maps
// - Flush selection restricts which entry classes flush
// - Selection governs both full and spanning-tree flush
// - Selection 00 means none and flush done
// - Priority from DA, SA, higher or lower
// - Flush trigger bits write one, self clear
module lec_ctrl #(
	parameter int                 PORTS      = 7,  // Switch port count
	parameter int                 HOST_PORT  = 6,  // Host port index
	parameter int                 FLUSH_CYC  = 16  // Cycles one flush takes
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             double_tag_en,
	input  wire lec_pkg::lec_lookup_t lookup,
	output logic      [6:0]       fwd_map,
	output logic      [2:0]       mac_address_priority,
	output logic                  flush_busy,
	output logic                  flush_dyn,
	output logic                  flush_sta,
	output logic                  flush_stp_only
);
	import lec_pkg::*;

	logic [7:0]  ctrl_two;      // Control register two
	logic        trig_all;      // Full-table flush trigger, self clearing
	logic        trig_stp;      // Spanning-tree flush trigger, self clearing
	logic [15:0] flush_cnt;     // Remaining flush cycles
	logic [1:0]  flush_cls;     // Class captured at flush start
	logic        stp_run;       // Running flush is the spanning-tree kind

	// Bus decode; only the low byte lane matters, the registers are eight bits
	// wide
	wire         wr_en    = psel && penable && pwrite;
	wire         hit_one  = (paddr == OFF_CTRL_ONE);
	wire         hit_two  = (paddr == OFF_CTRL_TWO);
	wire         hit_stat = (paddr == OFF_STATUS);
	wire         mapped   = hit_one || hit_two || hit_stat;
	wire [1:0]   sel_cls  = ctrl_two[POS_FLUSH +: 2];
	wire         wr_one   = wr_en && hit_one && pstrb[0];
	wire         wr_two   = wr_en && hit_two && pstrb[0];
	wire         start    = (trig_all || trig_stp) && !flush_busy && sel_cls != FL_NONE;

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Read mux: reserved bits read zero
	wire [31:0]  rd_mux   = hit_two  ? {24'h0, ctrl_two} :
	                        hit_one  ? {26'h0, trig_all, trig_stp, 4'h0} :
	                        hit_stat ? {31'h0, flush_busy} : 32'h0;

	// Read data is taken at the end of the setup cycle so the access phase
	// sees a flop; status may thus be one cycle old, which software can bear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// Control register two; flush field cleared on completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_two <= CTRL_TWO_RST;
		end else if (wr_two) begin
			ctrl_two <= pwdata[7:0];
		end else if (flush_busy && flush_cnt == 16'h1) begin
			ctrl_two[POS_FLUSH +: 2] <= FL_NONE;
		end
	end

	// Trigger bits: set by write of one, clear when flush starts or cannot run
	// A trigger that arrives while busy waits; once the flush ends the field
	// reads 00, so such a late trigger is dropped rather than run twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_all <= 1'b0;
			trig_stp <= 1'b0;
		end else if (wr_one) begin
			trig_all <= pwdata[BIT_FL_ALL];
			trig_stp <= pwdata[BIT_FL_STP];
		end else if (!flush_busy) begin
			trig_all <= 1'b0;
			trig_stp <= 1'b0;
		end
	end

	// Flush sequencer; both triggers use the same selection
	// The class is captured at start so a selection write in mid-flush cannot
	// change what the table walker removes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_busy <= 1'b0;
			flush_cnt  <= 16'h0;
			flush_cls  <= FL_NONE;
			stp_run    <= 1'b0;
		end else if (start) begin
			flush_busy <= 1'b1;
			flush_cnt  <= 16'(FLUSH_CYC);
			flush_cls  <= sel_cls;
			stp_run    <= trig_stp && !trig_all;
		end else if (flush_busy) begin
			flush_cnt <= flush_cnt - 16'h1;
			if (flush_cnt == 16'h1) begin
				flush_busy <= 1'b0;
			end
		end
	end

	// Class strobes to the table walker
	assign flush_dyn      = flush_busy && flush_cls[0];
	assign flush_sta      = flush_busy && flush_cls[1];
	assign flush_stp_only = flush_busy && stp_run;

	// Forwarding map selection; leaves both filters off at reset
	// The trap wins over every lookup result; a miss floods to the VLAN members
	wire        filt_on = lookup.is_static ? ctrl_two[BIT_STA_FLT]
	                                        : ctrl_two[BIT_DYN_FLT];
	wire [6:0]  host_m  = 7'(1 << HOST_PORT);
	wire        trap    = double_tag_en && ctrl_two[BIT_TRAP] && lookup.rsvd_mc;
	wire [6:0]  hit_map = filt_on ? (lookup.alu_map & lookup.vlan_map) : lookup.alu_map;
	wire [6:0]  next_fwd = trap ? host_m : (lookup.hit ? hit_map : lookup.vlan_map);

	// Priority selection; a tie in higher or lower mode gives the shared value
	lec_pri_sel_t psel_mode;
	assign psel_mode = lec_pri_sel_t'(ctrl_two[1:0]);
	logic [2:0] next_pri;
	always_comb begin
		unique case (psel_mode)
			PRI_DA:   next_pri = lookup.da_pri;
			PRI_SA:   next_pri = lookup.sa_pri;
			PRI_HIGH: next_pri = (lookup.da_pri > lookup.sa_pri) ? lookup.da_pri
			                                                      : lookup.sa_pri;
			PRI_LOW:  next_pri = (lookup.da_pri < lookup.sa_pri) ? lookup.da_pri
			                                                      : lookup.sa_pri;
		endcase
	end

	// Registered results, so the table walker sees one settled map per cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_map              <= 7'h0;
			mac_address_priority <= 3'h0;
		end else begin
			fwd_map              <= next_fwd;
			mac_address_priority <= next_pri;
		end
	end

	// Checks on the rules this block carries out; all are on pclk
	AST_TRAP: assert property (@(posedge pclk) disable iff (!presetn)
		double_tag_en && ctrl_two[BIT_TRAP] && lookup.rsvd_mc |=> fwd_map == $past(host_m))
		else $error("Trap did not send frame to host only");
	AST_DYN: assert property (@(posedge pclk) disable iff (!presetn)
		lookup.hit && !lookup.is_static && !lookup.rsvd_mc && ctrl_two[BIT_DYN_FLT]
		|=> fwd_map == ($past(lookup.alu_map) & $past(lookup.vlan_map)))
		else $error("Dynamic hit not VLAN filtered");
	AST_STA: assert property (@(posedge pclk) disable iff (!presetn)
		lookup.hit && lookup.is_static && !lookup.rsvd_mc && !ctrl_two[BIT_STA_FLT]
		|=> fwd_map == $past(lookup.alu_map))
		else $error("Static hit filtered while disabled");
	AST_CLS: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> flush_dyn == $past(sel_cls[0]) && flush_sta == $past(sel_cls[1]))
		else $error("Flush class mismatch");
	AST_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
		trig_stp && !flush_busy && sel_cls != FL_NONE |=> flush_busy)
		else $error("Spanning-tree flush did not start");
	AST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(flush_busy) && !$past(wr_two) |-> sel_cls == FL_NONE)
		else $error("Selection not zero after flush");
	AST_SC: assert property (@(posedge pclk) disable iff (!presetn)
		trig_all && !flush_busy && !wr_one |=> !trig_all)
		else $error("Flush trigger did not self clear");
	AST_PRI: assert property (@(posedge pclk) disable iff (!presetn)
		psel_mode == PRI_HIGH |=> mac_address_priority >= $past(lookup.sa_pri)
		&& mac_address_priority >= $past(lookup.da_pri))
		else $error("Higher priority not chosen");
	AST_TRAP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_two[BIT_TRAP] && lookup.rsvd_mc && !lookup.hit |=> fwd_map == $past(lookup.vlan_map))
		else $error("Reserved multicast trapped while trap disabled");
	AST_DYN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		lookup.hit && !lookup.is_static && !lookup.rsvd_mc && !ctrl_two[BIT_DYN_FLT]
		|=> fwd_map == $past(lookup.alu_map))
		else $error("Dynamic hit filtered while disabled");
	AST_STA_ON: assert property (@(posedge pclk) disable iff (!presetn)
		lookup.hit && lookup.is_static && !lookup.rsvd_mc && ctrl_two[BIT_STA_FLT]
		|=> fwd_map == ($past(lookup.alu_map) & $past(lookup.vlan_map)))
		else $error("Static hit not VLAN filtered");
	AST_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		psel_mode == PRI_LOW |=> mac_address_priority <= $past(lookup.sa_pri)
		&& mac_address_priority <= $past(lookup.da_pri))
		else $error("Lower priority not chosen");
	AST_NONE: assert property (@(posedge pclk) disable iff (!presetn)
		!flush_busy && sel_cls == FL_NONE |=> !flush_busy)
		else $error("Flush ran with no class selected");

	// Main scenarios that the bench should reach
	COV_FLUSH: cover property (@(posedge pclk) disable iff (!presetn) $fell(flush_busy));
	COV_STP:   cover property (@(posedge pclk) disable iff (!presetn) flush_stp_only);
	COV_TRAP:  cover property (@(posedge pclk) disable iff (!presetn) trap);
	COV_LOW:   cover property (@(posedge pclk) disable iff (!presetn) psel_mode == PRI_LOW);
endmodule

// *** verification/lec_ctrl_tb.sv ***
// Purpose: Self-checking bench for the lookup engine control block
// Assumes: Zero-wait APB slave; flush length shortened to 4 cycles
// Notes:   Expected values are built here from the field meanings
module lec_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lec_pkg::*;
	logic              pclk = 1'b0;      // 20 MHz bench clock
	logic              presetn = 1'b0;   // Held low for five cycles
	logic              psel = 1'b0;      // APB select
	logic              penable = 1'b0;   // APB access phase
	logic              pwrite = 1'b0;    // APB direction
	logic              dte = 1'b0;       // Double tagging mode
	logic [11:0]       paddr = 12'h000;  // APB byte address
	logic [31:0]       pwdata = 32'h0;   // APB write data
	logic [31:0]       prdata;           // APB read data
	logic [31:0]       rd;               // Last read data taken
	logic              pready;           // Slave answer
	logic              pslverr;          // Slave error
	logic              err;              // Last error taken
	lec_lookup_t       lookup = '0;      // Lookup result into the block
	logic [6:0]        fwd_map;          // Forwarding ports out
	logic [2:0]        pri;              // Chosen address priority
	logic              busy;             // Flush running
	logic              f_dyn;            // Dynamic class flushing
	logic              f_sta;            // Static class flushing
	logic              f_stp;            // Spanning-tree flush only
	int                n_mismatch = 0;   // Failed comparisons
	int                n_tests = 0;      // All comparisons
	always #25 pclk = ~pclk;
	// Short flush keeps the run brief; expectations do not depend on length
	lec_ctrl #(.FLUSH_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.double_tag_en(dte), .lookup(lookup), .fwd_map(fwd_map),
		.mac_address_priority(pri), .flush_busy(busy), .flush_dyn(f_dyn),
		.flush_sta(f_sta), .flush_stp_only(f_stp));
	task wrap_up;
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask
	// One APB transfer; holds the request until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			n_mismatch++;
			wrap_up;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Present one lookup, then sample the registered result
	task look(input logic t, h, s, m, input logic [2:0] dp, sp);
		@(posedge pclk);
		dte <= t;
		lookup <= '{h, s, m, 7'h3c, 7'h66, dp, sp};
		@(posedge pclk);
		#1;
	endtask
	// Bounded wait for the flush busy level
	task waitb(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 30) begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (busy !== v) begin
			n_mismatch++;
			wrap_up;
		end
	endtask
	task t_regs;
		apb(1'b0, OFF_CTRL_TWO, 32'h0);
		chk("ctrl_two reset", rd, 32'h0);
		chk("answer ready", {31'h0, pready}, 32'h1);
		apb(1'b0, 12'h3f0, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		// Software keeps both egress filters on whenever VLAN is in use
		apb(1'b1, OFF_CTRL_TWO, 32'h30);
		apb(1'b0, OFF_CTRL_TWO, 32'h0);
		chk("filters on", rd, 32'h30);
		apb(1'b0, OFF_CTRL_ONE, 32'h0);
		chk("triggers idle", rd, 32'h0);
	endtask
	task t_map;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFF_CTRL_TWO, 32'(i) << 4);
			look(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
			chk("dyn map", fwd_map, i[1] ? 7'h24 : 7'h3c);
			look(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 3'h0);
			chk("sta map", fwd_map, i[0] ? 7'h24 : 7'h3c);
		end
	endtask
	task t_trap;
		apb(1'b1, OFF_CTRL_TWO, 32'h40);
		look(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0);
		chk("trap on", fwd_map, 7'h40);
		look(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0);
		chk("trap no dtag", fwd_map, 7'h66);
		apb(1'b1, OFF_CTRL_TWO, 32'h0);
		look(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0);
		chk("trap off", fwd_map, 7'h66);
	endtask
	task t_pri;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFF_CTRL_TWO, 32'(i));
			look(1'b0, 1'b1, 1'b0, 1'b0, 3'h2, 3'h5);
			chk("priority", pri, (i == 1 || i == 2) ? 3'h5 : 3'h2);
		end
	endtask
	// Selection 00 drops the trigger; others run and clear to 00
	task t_flush(input logic [1:0] sel, input logic [7:0] trig);
		apb(1'b1, OFF_CTRL_TWO, {28'h0, sel, 2'h0});
		apb(1'b1, OFF_CTRL_ONE, {24'h0, trig});
		if (sel == FL_NONE) begin
			repeat (4) @(posedge pclk);
			#1;
			chk("busy none", busy, 1'b0);
		end else begin
			waitb(1'b1);
			chk("flush dyn", f_dyn, sel[0]);
			chk("flush sta", f_sta, sel[1]);
			chk("flush stp", f_stp, trig == 8'h10);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk("busy status", rd, 32'h1);
			waitb(1'b0);
			apb(1'b0, OFF_CTRL_TWO, 32'h0);
			chk("sel done", rd[3:2], FL_NONE);
		end
		apb(1'b0, OFF_CTRL_ONE, 32'h0);
		chk("trigger cleared", rd, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_map;
		t_trap;
		t_pri;
		t_flush(FL_DYN, 8'h20);
		t_flush(FL_STA, 8'h10);
		t_flush(FL_BOTH, 8'h20);
		t_flush(FL_NONE, 8'h20);
		wrap_up;
	end
endmodule
